/* File: shared/dxm_pkg.sv */
// package for the per-channel dma extended mode block: map, fields, defaults, carriers
// Functional notes
// - each dma channel except channel 4 has its own extended mode register, written through one shared write-only 8-bit port per channel group.
// - bits 1:0 of the written byte pick the channel inside the group and are not stored.
// - only bits 7:2 of the written byte are stored, holding data size, timing, end-of-process direction and stop enable.
// - four cycle timing modes are selectable per channel: compatible, type a, type b and burst.
// - timing sits in bits 5:4 with 00 compatible, 01 type a, 10 type b, and reset loads 00.
// - defaults are loaded only by reset; master clear or other programming leaves the settings alone.
// - after reset channels 0 to 3 are 8-bit i/o by bytes, compatible timing, end-of-process output.
// - after reset channels 4 to 7 are 16-bit i/o by words with shifted address, compatible timing, end-of-process output.
// - channel 4 is only the cascade channel and has no extended mode register.
// - bit 7 enables the channel stop registers for ring buffers and is cleared by reset.
// - bit 6 picks end-of-process as output or input while the channel is active, cleared to output by reset.
// - with end-of-process as input, an external end-of-process from the peripheral is accepted.
// - the end-of-process direction switches when the acknowledge changes to another channel.
// - during a changeover both ends drive end-of-process low until the device releases its buffer.
package dxm_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned NUM_CH = 8;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [11:0] IDX_LOW_GROUP = 12'h040b;
  localparam logic [11:0] IDX_HIGH_GROUP = 12'h04d6;
  localparam logic [15:0] ADDR_LOW_GROUP = {2'b00, IDX_LOW_GROUP, 2'b00};
  localparam logic [15:0] ADDR_HIGH_GROUP = {2'b00, IDX_HIGH_GROUP, 2'b00};
  localparam logic [15:0] ADDR_MIRROR_BASE = 16'h2000;
  localparam logic [15:0] ADDR_STATUS = 16'h2020;
  localparam int unsigned MIRROR_SEL_HI = 4;
  localparam int unsigned MIRROR_SEL_LO = 2;
  localparam int unsigned MIRROR_TAG_LO = 5;
  localparam int unsigned SEL_HI = 1;
  localparam int unsigned SEL_LO = 0;
  localparam int unsigned STORE_HI = 7;
  localparam int unsigned STORE_LO = 2;
  localparam logic [2:0] CASCADE_CH = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  localparam logic [1:0] TM_COMPAT = 2'b00;
  localparam logic [1:0] TM_TYPE_A = 2'b01;
  localparam logic [1:0] TM_TYPE_B = 2'b10;
  localparam logic [1:0] TM_BURST = 2'b11;
  localparam logic [1:0] DSIZE_BYTE_IO = 2'b00;
  localparam logic [1:0] DSIZE_WORD_SHIFT = 2'b01;

  // field order matches written byte bits 7..2
  typedef struct packed {
    logic stop_en;
    logic eop_in;
    logic [1:0] timing;
    logic [1:0] dsize;
  } dxm_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } dxm_wreq_t;

  typedef enum logic [1:0] {
    EOP_DRIVE = 2'b00,
    EOP_TURN = 2'b01,
    EOP_LISTEN = 2'b10
  } dxm_eop_st_t;

  localparam dxm_mode_t RST_MODE_LOW = {1'b0, 1'b0, TM_COMPAT, DSIZE_BYTE_IO};
  localparam dxm_mode_t RST_MODE_HIGH = {1'b0, 1'b0, TM_COMPAT, DSIZE_WORD_SHIFT};
endpackage : dxm_pkg

/* File: src/dxm_ext_mode.sv */
// per-channel dma extended mode registers with end-of-process direction control
`timescale 1ns/1ns
module dxm_ext_mode (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] dack,
  input wire logic tc,
  input wire logic end_of_process_i,
  output logic end_of_process_o,
  output logic end_of_process_oe,
  output dxm_pkg::dxm_mode_t active_mode,
  output logic active_valid,
  output logic ext_eop
);

  function automatic logic [2:0] chan_of(input logic high, input logic [1:0] sel);
    chan_of = {high, sel};
  endfunction : chan_of

  function automatic logic [2:0] onehot_idx(input logic [7:0] oh);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (oh[i]) begin
        idx = 3'(i);
      end
    end
    onehot_idx = idx;
  endfunction : onehot_idx

  // ---------------- axi write path ----------------
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_hold_r;
  logic w_hold_r;
  dxm_pkg::dxm_wreq_t wreq_r;
  dxm_pkg::dxm_mode_t mode_r [dxm_pkg::NUM_CH];

  wire aw_take = s_axi_awvalid && awready_r;
  wire w_take = s_axi_wvalid && wready_r;
  wire do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  wire hit_low = wreq_r.addr == dxm_pkg::ADDR_LOW_GROUP;
  wire hit_high = wreq_r.addr == dxm_pkg::ADDR_HIGH_GROUP;
  wire [1:0] wr_sel = wreq_r.data[dxm_pkg::SEL_HI:dxm_pkg::SEL_LO];
  wire [2:0] wr_ch = chan_of(hit_high, wr_sel);
  // channel 4 has no register; a write selecting it is dropped
  wire wr_en = do_wr && (hit_low || hit_high) && wreq_r.strb[0]
               && (wr_ch != dxm_pkg::CASCADE_CH);
  wire dxm_pkg::dxm_mode_t wr_val =
    dxm_pkg::dxm_mode_t'(wreq_r.data[dxm_pkg::STORE_HI:dxm_pkg::STORE_LO]);
  wire [1:0] wr_resp = (hit_low || hit_high) ? dxm_pkg::RESP_OKAY : dxm_pkg::RESP_DECERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= dxm_pkg::RESP_OKAY;
      wreq_r <= '0;
    end else if (ce) begin
      if (!aw_hold_r && !bvalid_r && !awready_r) begin
        awready_r <= 1'b1;
      end
      if (!w_hold_r && !bvalid_r && !wready_r) begin
        wready_r <= 1'b1;
      end
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
        wreq_r.addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
        wreq_r.data <= s_axi_wdata;
        wreq_r.strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_resp;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // defaults only come from reset; no other event reloads them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < 4; c++) begin
        mode_r[c] <= dxm_pkg::RST_MODE_LOW;
      end
      for (int c = 4; c < 8; c++) begin
        mode_r[c] <= dxm_pkg::RST_MODE_HIGH;
      end
    end else if (ce && wr_en) begin
      // timing code is stored whole, all four modes selectable
      mode_r[wr_ch] <= wr_val;
    end
  end

  // ---------------- end-of-process pin ----------------
  logic eop_s1_r;
  logic eop_s2_r;
  logic eop_s3_r;
  logic eop_lvl_r;
  logic eop_lvl_d_r;
  logic [7:0] dack_r;
  dxm_pkg::dxm_eop_st_t eop_st_r;
  dxm_pkg::dxm_eop_st_t eop_st_nxt;
  logic eop_o_r;
  logic eop_oe_r;
  logic ext_eop_r;
  dxm_pkg::dxm_mode_t active_mode_r;
  logic active_valid_r;

  wire dack_chg = dack != dack_r;
  wire new_valid = |dack;
  wire dxm_pkg::dxm_mode_t new_mode = mode_r[onehot_idx(dack)];
  wire new_wants_in = new_valid && new_mode.eop_in;
  wire eop_rise = eop_lvl_r && !eop_lvl_d_r;

  always_comb begin
    eop_st_nxt = eop_st_r;
    case (eop_st_r)
      dxm_pkg::EOP_DRIVE: begin
        if (dack_chg && new_wants_in) begin
          eop_st_nxt = dxm_pkg::EOP_TURN;
        end
      end
      dxm_pkg::EOP_TURN: begin
        if (dack_chg && !new_wants_in) begin
          eop_st_nxt = dxm_pkg::EOP_DRIVE;
        end else begin
          eop_st_nxt = dxm_pkg::EOP_LISTEN;
        end
      end
      dxm_pkg::EOP_LISTEN: begin
        if (dack_chg && !new_wants_in) begin
          eop_st_nxt = dxm_pkg::EOP_DRIVE;
        end
      end
      default: begin
        eop_st_nxt = dxm_pkg::EOP_DRIVE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eop_s1_r <= 1'b0;
      eop_s2_r <= 1'b0;
      eop_s3_r <= 1'b0;
      eop_lvl_r <= 1'b0;
      eop_lvl_d_r <= 1'b0;
    end else if (ce) begin
      eop_s1_r <= end_of_process_i;
      eop_s2_r <= eop_s1_r;
      eop_s3_r <= eop_s2_r;
      if (eop_s2_r == eop_s3_r) begin
        eop_lvl_r <= eop_s3_r;
      end
      eop_lvl_d_r <= eop_lvl_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dack_r <= 8'h00;
      eop_st_r <= dxm_pkg::EOP_DRIVE;
      active_mode_r <= '0;
      active_valid_r <= 1'b0;
    end else if (ce) begin
      dack_r <= dack;
      eop_st_r <= eop_st_nxt;
      active_mode_r <= new_valid ? new_mode : '0;
      active_valid_r <= new_valid;
    end
  end

  // the turn state keeps the buffer on but low, so the overlap with the
  // peripheral is always at the inactive level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eop_o_r <= 1'b0;
      eop_oe_r <= 1'b1;
      ext_eop_r <= 1'b0;
    end else if (ce) begin
      eop_oe_r <= (eop_st_nxt != dxm_pkg::EOP_LISTEN);
      eop_o_r <= (eop_st_nxt == dxm_pkg::EOP_DRIVE) && !dack_chg
                 && tc && active_valid_r;
      ext_eop_r <= (eop_st_r == dxm_pkg::EOP_LISTEN) && !dack_chg
                   && active_valid_r && active_mode_r.eop_in && eop_rise;
    end
  end

  // ---------------- axi read path ----------------
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire ar_take = s_axi_arvalid && arready_r;
  wire rd_wo = (s_axi_araddr == dxm_pkg::ADDR_LOW_GROUP)
               || (s_axi_araddr == dxm_pkg::ADDR_HIGH_GROUP);
  wire rd_mirror = s_axi_araddr[15:dxm_pkg::MIRROR_TAG_LO]
                   == dxm_pkg::ADDR_MIRROR_BASE[15:dxm_pkg::MIRROR_TAG_LO];
  wire rd_status = s_axi_araddr == dxm_pkg::ADDR_STATUS;
  wire [2:0] rd_ch = s_axi_araddr[dxm_pkg::MIRROR_SEL_HI:dxm_pkg::MIRROR_SEL_LO];
  wire [31:0] mirror_word = (rd_ch == dxm_pkg::CASCADE_CH) ? 32'h0000_0000
                            : {24'h00_0000, mode_r[rd_ch], 2'b00};
  wire [31:0] status_word = {16'h0000, dack_r, 1'b0, eop_lvl_r, eop_oe_r, eop_o_r,
                             2'b00, eop_st_r};
  // write-only ports read as zero but still answer okay
  wire [31:0] rd_data = rd_mirror ? mirror_word : (rd_status ? status_word : 32'h0000_0000);
  wire [1:0] rd_resp = (rd_wo || rd_mirror || rd_status) ? dxm_pkg::RESP_OKAY
                       : dxm_pkg::RESP_DECERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= dxm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (!rvalid_r && !arready_r) begin
        arready_r <= 1'b1;
      end
      if (ar_take) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_data;
        rresp_r <= rd_resp;
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign end_of_process_o = eop_o_r;
  assign end_of_process_oe = eop_oe_r;
  assign active_mode = active_mode_r;
  assign active_valid = active_valid_r;
  assign ext_eop = ext_eop_r;

endmodule : dxm_ext_mode

/* File: test/dxm_ext_mode_chk.sv */
// concurrent checks on the extended mode block ports
`timescale 1ns/1ns
module dxm_ext_mode_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] dack,
  input wire logic tc,
  input wire logic end_of_process_o,
  input wire logic end_of_process_oe,
  input wire dxm_pkg::dxm_mode_t active_mode,
  input wire logic active_valid,
  input wire logic ext_eop
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && end_of_process_oe && !active_valid)
    else $error("outputs not quiet after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  done_src_a: assert property (end_of_process_o |-> $past(tc))
    else $error("process end driven without terminal count");
  turn_low_a: assert property (end_of_process_oe ##1 !end_of_process_oe
    |-> !$past(end_of_process_o)) else $error("buffer released while driving high");
  to_input_a: assert property (end_of_process_oe && $changed(dack) ##1 active_mode.eop_in
    |-> end_of_process_oe && !end_of_process_o ##1 !end_of_process_oe)
    else $error("direction change not two cycles");
  ext_in_a: assert property (ext_eop |-> !end_of_process_oe ##1 !ext_eop)
    else $error("external end accepted while driving");
  cover property (ext_eop);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($fell(end_of_process_oe));
endmodule : dxm_ext_mode_chk

/* File: test/dxm_periph_model.sv */
// peripheral on the pin: answers its acknowledge, fires on command
`timescale 1ns/1ns
module dxm_periph_model (
  input wire logic aclk,
  input wire logic [7:0] dack,
  input wire logic [7:0] in_mask,
  input wire logic fire,
  input wire logic dev_o,
  input wire logic dev_oe,
  output logic pin,
  output logic clash
);
  logic drv;
  logic last_r = 1'b0;
  // drives only while one of its input-mode channels is acknowledged
  assign drv = |(dack & in_mask);
  // low unless firing; an undriven pin toggles so no stale level passes
  assign pin = dev_oe ? dev_o : (drv ? fire : ~last_r);
  assign clash = dev_oe && drv && (dev_o || fire);
  always_ff @(posedge aclk) last_r <= pin;
endmodule : dxm_periph_model

/* File: test/dxm_ext_mode_tb.sv */
// self-checking bench for the extended mode block
`timescale 1ns/1ns
module dxm_ext_mode_tb;
  localparam logic [15:0] LOW = dxm_pkg::ADDR_LOW_GROUP;
  localparam logic [15:0] HIGH = dxm_pkg::ADDR_HIGH_GROUP;
  localparam logic [1:0] OK = dxm_pkg::RESP_OKAY;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, tc = 0, fire = 0, clash, end_of_process_i;
  logic ce = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic end_of_process_o, end_of_process_oe, active_valid, ext_eop;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] dack = 0, in_mask = 0;
  dxm_pkg::dxm_mode_t active_mode;
  int num_errors = 0, n_compared = 0;
  always #50 aclk = ~aclk;
  dxm_ext_mode uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .dack, .tc, .end_of_process_i, .end_of_process_o,
    .end_of_process_oe, .active_mode, .active_valid, .ext_eop);
  dxm_periph_model per (.aclk, .dack, .in_mask, .fire, .dev_o(end_of_process_o),
    .dev_oe(end_of_process_oe), .pin(end_of_process_i), .clash);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task wr(input logic [15:0] a, input logic [7:0] b, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, b};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    if (n == 40) begin
      num_errors++;
      report_and_stop();
    end
  endtask : wr
  task rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    if (n == 40) begin
      num_errors++;
      report_and_stop();
    end
  endtask : rd
  function automatic logic [15:0] mir(input int c);
    return dxm_pkg::ADDR_MIRROR_BASE + 16'(c * 4);
  endfunction : mir
  // sel in 1:0, stop and timing follow the channel, dsize marks the group
  function automatic logic [7:0] pat(input int c);
    logic [1:0] k;
    k = 2'(c % 4);
    return {k[0], 1'b0, k, 1'b1, c > 3, k};
  endfunction : pat
  task restart;
    aresetn <= 1'b0;
    tick(16);
    aresetn <= 1'b1;
    tick(2);
    for (int c = 0; c < 8; c++)
      rd(mir(c), c > 4 ? {24'h00_0000, dxm_pkg::RST_MODE_HIGH, 2'b00} : 32'h0000_0000, OK);
    $display("defaults test done");
  endtask : restart
  always @(posedge aclk)
    if (aresetn && clash === 1'b1) chk("clash", 0, 1);
  initial begin
    int n;
    restart();
    for (int c = 0; c < 8; c++) wr(c > 3 ? HIGH : LOW, pat(c), OK);
    for (int c = 0; c < 8; c++)
      rd(mir(c), c == 4 ? 32'h0000_0000 : {24'h00_0000, pat(c) & 8'hfc}, OK);
    wr(16'h0100, 8'h00, dxm_pkg::RESP_DECERR);
    rd(16'h0100, 32'h0000_0000, dxm_pkg::RESP_DECERR);
    rd(LOW, 32'h0000_0000, OK);
    $display("programming test done");
    restart();
    wr(LOW, 8'h41, OK);
    // with the enable low the grant must not be taken up
    ce <= 1'b0;
    dack <= 8'h04;
    tick(3);
    chk("freeze", 0, active_valid);
    ce <= 1'b1;
    in_mask <= 8'h02;
    dack <= 8'h04;
    tick(3);
    tc <= 1'b1;
    tick(1);
    tc <= 1'b0;
    tick(1);
    chk("drive", 1, end_of_process_o);
    dack <= 8'h02;
    tick(2);
    chk("turn", 2, {end_of_process_oe, end_of_process_o});
    tick(1);
    chk("listen", 0, end_of_process_oe);
    chk("mode", 32'h0000_0010, 32'(active_mode));
    tick(5);
    fire <= 1'b1;
    for (n = 0; n < 12 && ext_eop !== 1'b1; n++) @(posedge aclk);
    chk("ext", 1, ext_eop);
    fire <= 1'b0;
    dack <= 8'h00;
    tick(3);
    chk("back", 1, end_of_process_oe);
    $display("direction test done");
    report_and_stop();
  end
endmodule : dxm_ext_mode_tb
bind dxm_ext_mode dxm_ext_mode_chk chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .dack, .tc,
  .end_of_process_o, .end_of_process_oe, .active_mode, .active_valid, .ext_eop);
